// ==== core/data_load_address_unit.v ====
// load unit: address generation, base update, memory read, destination write
//
// Overview of operation
// - halfword lands low, sign or zero extended
// - dest side bit picks file A or B
// - long form field 100 signed, 000 unsigned
// - long form on second unit, global bases
// - long form only adds, linear, direct address
// - long form word constant shifted left two
// - short word offset scaled four, add/subtract
// - unit select picks file for base/offset
// - pre/offset use sum; post uses old base
// - circular mode for regs four-seven when selected
// - word fills 32 bits, any file
// - missing offset: 1 if modifying, else 0
// - read in stage one, write stage five
// - modified base written in stage one
`timescale 1ns/1ps
`include "load_unit_defines.vh"
module data_load_address_unit (
    input  wire        core_clk,
    input  wire        reset,
    // instruction issue, one load per cycle, sampled in stage one
    input  wire        issue_valid,
    input  wire        issue_cond,
    input  wire        issue_long_form,
    input  wire [2:0]  issue_operation_field,
    input  wire        issue_unit_select,
    input  wire        issue_dest_side,
    input  wire [3:0]  issue_dest_idx,
    input  wire [3:0]  issue_base_idx,
    input  wire [3:0]  issue_offset_idx,
    input  wire [3:0]  issue_addr_option,
    input  wire        issue_offset_given,
    input  wire [4:0]  issue_short_unsigned_offset,
    input  wire [14:0] issue_long_unsigned_offset,
    // data memory system
    output reg         mem_read,
    output reg  [31:0] mem_address,
    output reg         mem_word,
    input  wire [31:0] mem_rdata,
    // avalon-mm slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest
);
    // the two register files
    reg  [31:0] file_a [0:15];
    reg  [31:0] file_b [0:15];

    reg  [31:0] addressing_mode_register;
    reg  [31:0] load_count;
    reg  [31:0] last_address;

    // pipeline stage two to five
    reg         s2_valid;
    reg         s3_valid;
    reg         s4_valid;
    reg         s5_valid;
    reg         s2_side;
    reg         s3_side;
    reg         s4_side;
    reg         s5_side;
    reg  [3:0]  s2_idx;
    reg  [3:0]  s3_idx;
    reg  [3:0]  s4_idx;
    reg  [3:0]  s5_idx;
    reg  [2:0]  s2_opf;
    reg  [2:0]  s3_opf;
    reg  [2:0]  s4_opf;
    reg         s2_high;
    reg         s3_high;
    reg         s4_high;
    reg  [31:0] s5_data;

    // decode of the issued load
    wire        is_word;
    wire        is_half;
    wire        known_kind;
    wire        fire;
    wire        on_second;
    wire [1:0]  scale;
    wire [31:0] base_value;
    wire [31:0] offset_reg_value;
    wire [31:0] raw_offset;
    wire [31:0] scaled_offset;
    wire        modifying;
    wire        post_mode;
    wire        subtract;
    wire [31:0] gen_result;
    wire [31:0] access_address;
    wire        writes_base;
    wire        circ_candidate;
    wire [3:0]  mode_slot;
    wire [1:0]  mode_bits;
    reg         circular;
    reg  [4:0]  block_exp;
    wire [15:0] half_value;
    wire [31:0] loaded_value;
    wire        bus_hit_a;
    wire        bus_hit_b;
    wire [3:0]  bus_idx;
    reg  [31:0] bus_value;
    reg  [31:0] merged;

    // operation field decode; unknown codes do nothing
    assign is_word    = (issue_operation_field == `OPF_WORD);
    assign is_half    = (issue_operation_field == `OPF_HALF_SIGNED) ||
                        (issue_operation_field == `OPF_HALF_UNSIGNED);
    assign known_kind = is_word || is_half;
    assign fire       = issue_valid && issue_cond && known_kind;
    assign scale      = is_word ? `SHIFT_WORD : `SHIFT_HALF;

    // long form always runs on the second unit against the B file
    assign on_second = issue_long_form | issue_unit_select;

    // base and offset are read in stage one
    assign base_value = issue_long_form ?
        (issue_unit_select ? file_b[`SECOND_GLOBAL_BASE] : file_b[`FIRST_GLOBAL_BASE])
        : (on_second ? file_b[issue_base_idx] : file_a[issue_base_idx]);
    assign offset_reg_value = on_second ? file_b[issue_offset_idx]
                                        : file_a[issue_offset_idx];

    assign modifying = issue_addr_option[`OPT_MODIFY_BIT] & ~issue_long_form;
    assign post_mode = modifying & issue_addr_option[`OPT_POST_BIT];
    // long form never subtracts
    assign subtract  = ~issue_long_form & ~issue_addr_option[`OPT_ADD_BIT];

    // choose offset; absent offset means a step of one or nothing
    assign raw_offset =
        issue_long_form ? {17'h00000, issue_long_unsigned_offset} :
        !issue_offset_given ? (modifying ? 32'h00000001 : 32'h00000000) :
        issue_addr_option[`OPT_REG_OFFSET_BIT] ? offset_reg_value :
        {27'h0000000, issue_short_unsigned_offset};
    assign scaled_offset = raw_offset << scale;

    // circular addressing only for registers four to seven, short form
    assign circ_candidate = ~issue_long_form && (issue_base_idx[3:2] == 2'h1);
    // two bits per register: slots 0-3 for A4-A7, slots 4-7 for B4-B7
    assign mode_slot = {1'b0, on_second, issue_base_idx[1:0]};
    assign mode_bits = addressing_mode_register[{mode_slot, 1'b0} +: 2];

    // modes 01 and 10 wrap inside their block, 00 and 11 stay linear
    always @* begin
        case (mode_bits)
            `AMODE_CIRC_BK0: begin
                circular  = circ_candidate;
                block_exp = addressing_mode_register[`AMODE_BK0_LSB +: 5];
            end
            `AMODE_CIRC_BK1: begin
                circular  = circ_candidate;
                block_exp = addressing_mode_register[`AMODE_BK1_LSB +: 5];
            end
            default: begin
                circular  = 1'b0;
                block_exp = addressing_mode_register[`AMODE_BK0_LSB +: 5];
            end
        endcase
    end

    address_generator u_address_generator (
        .base      (base_value),
        .offset    (scaled_offset),
        .subtract  (subtract),
        .circular  (circular),
        .block_exp (block_exp),
        .result    (gen_result)
    );

    // post modes access at the old base, all others at the result
    assign access_address = post_mode ? base_value : gen_result;
    assign writes_base    = fire && modifying;

    // pick the addressed halfword of the returned word and extend it
    assign half_value   = s4_high ? mem_rdata[31:16] : mem_rdata[15:0];
    assign loaded_value =
        (s4_opf == `OPF_WORD) ? mem_rdata :
        (s4_opf == `OPF_HALF_SIGNED) ? {{16{half_value[15]}}, half_value} :
        {16'h0000, half_value};

    // issue the memory read the cycle after stage one
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_read     <= 1'b0;
            mem_address  <= 32'h00000000;
            mem_word     <= 1'b0;
            last_address <= 32'h00000000;
            load_count   <= 32'h00000000;
        end else begin
            mem_read <= fire;
            if (fire) begin
                mem_address  <= access_address;
                mem_word     <= is_word;
                last_address <= access_address;
                load_count   <= load_count + 32'h00000001;
            end
        end
    end

    // stage carriers; data is captured as it leaves stage four
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s2_valid <= 1'b0;
            s3_valid <= 1'b0;
            s4_valid <= 1'b0;
            s5_valid <= 1'b0;
            s2_side  <= 1'b0;
            s3_side  <= 1'b0;
            s4_side  <= 1'b0;
            s5_side  <= 1'b0;
            s2_idx   <= 4'h0;
            s3_idx   <= 4'h0;
            s4_idx   <= 4'h0;
            s5_idx   <= 4'h0;
            s2_opf   <= 3'h0;
            s3_opf   <= 3'h0;
            s4_opf   <= 3'h0;
            s2_high  <= 1'b0;
            s3_high  <= 1'b0;
            s4_high  <= 1'b0;
            s5_data  <= 32'h00000000;
        end else begin
            s2_valid <= fire;
            s3_valid <= s2_valid;
            s4_valid <= s3_valid;
            s5_valid <= s4_valid;
            s2_side  <= issue_dest_side;
            s3_side  <= s2_side;
            s4_side  <= s3_side;
            s5_side  <= s4_side;
            s2_idx   <= issue_dest_idx;
            s3_idx   <= s2_idx;
            s4_idx   <= s3_idx;
            s5_idx   <= s4_idx;
            s2_opf   <= issue_operation_field;
            s3_opf   <= s2_opf;
            s4_opf   <= s3_opf;
            // bit one of the address picks the half; bit zero is ignored
            s2_high  <= access_address[1];
            s3_high  <= s2_high;
            s4_high  <= s3_high;
            if (s4_valid) begin
                s5_data <= loaded_value;
            end
        end
    end

    // register bus decode of the files
    assign bus_hit_a = (avs_address >= `REG_FILE_A_BASE) &&
                       (avs_address < (`REG_FILE_A_BASE + `REG_FILE_SPAN));
    assign bus_hit_b = (avs_address >= `REG_FILE_B_BASE) &&
                       (avs_address < (`REG_FILE_B_BASE + `REG_FILE_SPAN));
    assign bus_idx   = avs_address[5:2];

    // value seen by a read, also the base for byte-lane merging
    always @* begin
        case (avs_address)
            `REG_ADDRESSING_MODE: bus_value = addressing_mode_register;
            `REG_LOAD_COUNT:      bus_value = load_count;
            `REG_LAST_ADDRESS:    bus_value = last_address;
            `REG_PIPE_STATUS:     bus_value = {28'h0000000, s5_valid, s4_valid,
                                               s3_valid, s2_valid};
            default: begin
                if (bus_hit_a) begin
                    bus_value = file_a[bus_idx];
                end else if (bus_hit_b) begin
                    bus_value = file_b[bus_idx];
                end else begin
                    bus_value = 32'h00000000;
                end
            end
        endcase
    end

    // byte enables select which lanes a write replaces
    always @* begin
        merged = bus_value;
        if (avs_byteenable[0]) begin
            merged[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            merged[15:8] = avs_writedata[15:8];
        end
        if (avs_byteenable[2]) begin
            merged[23:16] = avs_writedata[23:16];
        end
        if (avs_byteenable[3]) begin
            merged[31:24] = avs_writedata[31:24];
        end
    end

    // one wait cycle per access; the write lands when wait is low
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            avs_waitrequest          <= 1'b1;
            avs_readdata             <= 32'h00000000;
            addressing_mode_register <= `AMODE_RESET;
        end else begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? bus_value : 32'h00000000;
            end else begin
                avs_waitrequest <= 1'b1;
                if (avs_write && !avs_waitrequest &&
                    avs_address == `REG_ADDRESSING_MODE) begin
                    addressing_mode_register <= merged & `AMODE_USED_MASK;
                end
            end
        end
    end

    // register file writes: bus, then base update, then load result;
    // later statements win, so a load beats a same-cycle bus write
    always @(posedge core_clk) begin
        if (avs_write && !avs_waitrequest && bus_hit_a) begin
            file_a[bus_idx] <= merged;
        end
        if (avs_write && !avs_waitrequest && bus_hit_b) begin
            file_b[bus_idx] <= merged;
        end
        if (writes_base) begin
            if (on_second) begin
                file_b[issue_base_idx] <= gen_result;
            end else begin
                file_a[issue_base_idx] <= gen_result;
            end
        end
        if (s5_valid) begin
            if (s5_side) begin
                file_b[s5_idx] <= s5_data;
            end else begin
                file_a[s5_idx] <= s5_data;
            end
        end
    end
endmodule

// ==== core/load_unit_defines.vh ====
// constants for the load address and data path
`ifndef LOAD_UNIT_DEFINES_VH
`define LOAD_UNIT_DEFINES_VH

// operation field codes of a load
`define OPF_HALF_SIGNED      3'h4
`define OPF_HALF_UNSIGNED    3'h0
`define OPF_WORD             3'h6

// offset scaling, left shift in bits
`define SHIFT_HALF           2'h1
`define SHIFT_WORD           2'h2

// addressing option field bits
`define OPT_ADD_BIT          0
`define OPT_POST_BIT         1
`define OPT_REG_OFFSET_BIT   2
`define OPT_MODIFY_BIT       3

// global base registers in the second file
`define FIRST_GLOBAL_BASE    4'hE
`define SECOND_GLOBAL_BASE   4'hF

// addressing mode register layout
`define AMODE_BK0_LSB        16
`define AMODE_BK1_LSB        21
`define AMODE_SIDE_B_LSB     8
`define AMODE_LINEAR         2'h0
`define AMODE_CIRC_BK0       2'h1
`define AMODE_CIRC_BK1       2'h2
`define AMODE_RESET          32'h00000000
`define AMODE_USED_MASK      32'h03FFFFFF

// register bus byte offsets
`define REG_ADDRESSING_MODE  8'h00
`define REG_LOAD_COUNT       8'h04
`define REG_LAST_ADDRESS     8'h08
`define REG_PIPE_STATUS      8'h0C
`define REG_FILE_A_BASE      8'h40
`define REG_FILE_B_BASE      8'h80
`define REG_FILE_SPAN        8'h40

// pipeline timing: memory answers two cycles after its request
`define MEM_READ_LATENCY     2

`endif

// ==== core/address_generator.v ====
// base plus or minus scaled offset, linear or circular
`timescale 1ns/1ps
module address_generator (
    input  wire [31:0] base,
    input  wire [31:0] offset,
    input  wire        subtract,
    input  wire        circular,
    input  wire [4:0]  block_exp,
    output reg  [31:0] result
);
    wire [5:0]  shift_amount;
    wire [32:0] block_size;
    wire [31:0] block_mask;
    wire [31:0] linear_sum;

    // circular block is 2^(n+1) bytes; n of 31 covers the full space
    assign shift_amount = {1'b0, block_exp} + 6'h01;
    assign block_size   = 33'h000000001 << shift_amount;
    assign block_mask   = block_size[31:0] - 32'h00000001;
    assign linear_sum   = subtract ? (base - offset) : (base + offset);

    // only the bits inside the block wrap, the rest keep the base
    always @* begin
        if (circular) begin
            result = (base & ~block_mask) | (linear_sum & block_mask);
        end else begin
            result = linear_sum;
        end
    end
endmodule

// ==== sim/load_unit_props.sv ====
// assertion checker for the load unit ports
`timescale 1ns/1ps
module load_unit_props (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        issue_valid,
    input wire logic        issue_cond,
    input wire logic [2:0]  issue_operation_field,
    input wire logic        mem_read,
    input wire logic [31:0] mem_address,
    input wire logic        mem_word,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // a load counts only with a true predicate and a known field
    wire known = issue_operation_field == 3'h4 || issue_operation_field == 3'h0
        || issue_operation_field == 3'h6;
    wire load_taken = issue_valid && issue_cond && known;

    chk_read_follows: assert property (load_taken |=> mem_read)
        else $error("load issued without memory read");
    chk_false_quiet: assert property (!load_taken |=> !mem_read)
        else $error("memory read without a taken load");
    chk_bad_field: assert property (issue_valid && issue_cond && !known |=> !mem_read)
        else $error("unknown field caused a read");
    chk_word_flag: assert property (load_taken |=>
        mem_word == ($past(issue_operation_field) == 3'h6))
        else $error("access size flag wrong");
    chk_addr_holds: assert property (!mem_read |-> $stable(mem_address))
        else $error("address moved without a load");
    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    chk_idle_wait: assert property (!avs_read && !avs_write && avs_waitrequest
        |=> avs_waitrequest)
        else $error("bus answered with no request");

    cover property (mem_read && mem_word);
    cover property (mem_read && !mem_word);
    cover property (avs_write && !avs_waitrequest);
endmodule

bind data_load_address_unit load_unit_props load_unit_props_inst (
    .core_clk(core_clk), .reset(reset), .issue_valid(issue_valid),
    .issue_cond(issue_cond), .issue_operation_field(issue_operation_field),
    .mem_read(mem_read), .mem_address(mem_address), .mem_word(mem_word),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// ==== sim/load_memory_model.sv ====
// data memory model answering two cycles after each read
`timescale 1ns/1ps
module load_memory_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        mem_read,
    input  wire logic [31:0] mem_address,
    output logic      [31:0] mem_rdata
);
    logic        pend;
    logic [31:0] addr;

    // high half negative, low half positive, so extension shows
    // data valid one cycle only; otherwise it flips each cycle
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend <= 1'b0;
            addr <= 32'h00000000;
            mem_rdata <= 32'h00000000;
        end else begin
            pend <= mem_read;
            addr <= mem_address;
            if (pend)
                mem_rdata <= {16'h8000 | addr[15:0], addr[15:0] & 16'h7FFF};
            else
                mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ==== sim/data_load_address_unit_test.sv ====
// self-checking bench for the load unit
`timescale 1ns/1ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module data_load_address_unit_test;
    logic        core_clk = 0;
    logic        reset = 1;
    logic        iv = 0, ic = 0, lf = 0, us = 0, ds = 0, og = 0;
    logic [2:0]  opf = 0;
    logic [3:0]  di = 0, bi = 0, oi = 0, ao = 0;
    logic [4:0]  c5r = 0;
    logic [14:0] c15r = 0;
    logic [7:0]  avs_address = 0;
    logic        avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, mem_address, mem_rdata, v;
    logic        avs_waitrequest, mem_read, mem_word;
    int          n_fail = 0, tests_run = 0, cyc = 0;

    always #2.5 core_clk = ~core_clk;

    data_load_address_unit data_load_address_unit_inst (
        .core_clk(core_clk), .reset(reset), .issue_valid(iv), .issue_cond(ic),
        .issue_long_form(lf), .issue_operation_field(opf), .issue_unit_select(us),
        .issue_dest_side(ds), .issue_dest_idx(di), .issue_base_idx(bi),
        .issue_offset_idx(oi), .issue_addr_option(ao), .issue_offset_given(og),
        .issue_short_unsigned_offset(c5r), .issue_long_unsigned_offset(c15r),
        .mem_read(mem_read), .mem_address(mem_address), .mem_word(mem_word),
        .mem_rdata(mem_rdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    load_memory_model load_memory_model_inst (.core_clk(core_clk), .reset(reset),
        .mem_read(mem_read), .mem_address(mem_address), .mem_rdata(mem_rdata));

    task automatic results;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard, whole run needs well under this
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            results;
        end
    end

    // bus cycle: hold until waitrequest is sampled low, take data at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000, v);
        `CHECK(v, e)
    endtask

    // one load; access checked in the cycle after issue, destination later
    task automatic ld(input logic l, input logic [2:0] op, input logic y, s,
                      input logic [3:0] d, b, o, opt, input logic g,
                      input logic [4:0] c5, input logic [14:0] c15, input logic cnd,
                      input logic [31:0] ea, ed);
        logic ex;
        ex = cnd && (op == 3'h4 || op == 3'h0 || op == 3'h6);
        @(posedge core_clk);
        {iv, ic, lf, opf, us, ds, di, bi, oi} <= {1'b1, cnd, l, op, y, s, d, b, o};
        {ao, og, c5r, c15r} <= {opt, g, c5, c15};
        @(posedge core_clk);
        iv <= 1'b0;
        @(negedge core_clk);
        `CHECK(mem_read, ex)
        if (ex) `CHECK(mem_address, ea)
        if (ex) `CHECK(mem_word, op == 3'h6)
        repeat (6) @(posedge core_clk);
        chk((s ? 8'h80 : 8'h40) + {2'b00, d, 2'b00}, ed);
    endtask

    // bases kept aligned for their access size
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b1, 8'h50, 32'h00000100, v);
        bus(1'b1, 8'h94, 32'h00000202, v);
        bus(1'b1, 8'h88, 32'h00000003, v);
        bus(1'b1, 8'hB8, 32'h00001000, v);
        bus(1'b1, 8'hBC, 32'h00002000, v);
        bus(1'b1, 8'h54, 32'h00000300, v);
        bus(1'b1, 8'h44, 32'h00000002, v);
        bus(1'b1, 8'h70, 32'h5A5A5A5A, v);
        chk(8'hF0, 32'h00000000);
        ld(0, 3'h6, 0, 1, 4'h6, 4'h4, 4'h0, 4'h9, 1, 5'h01, 15'h0, 1, 32'h104, 32'h81040104);
        chk(8'h50, 32'h00000104);
        ld(0, 3'h4, 1, 0, 4'h8, 4'h5, 4'h2, 4'hF, 1, 5'h0, 15'h0, 1, 32'h202, 32'hFFFF8202);
        chk(8'h94, 32'h00000208);
        ld(1, 3'h0, 0, 0, 4'h9, 4'h0, 4'h0, 4'h0, 0, 5'h0, 15'h5, 1, 32'h100A, 32'h0000900A);
        ld(1, 3'h4, 0, 0, 4'hE, 4'h0, 4'h0, 4'h0, 0, 5'h0, 15'h4, 1, 32'h1008, 32'h00001008);
        ld(1, 3'h6, 1, 1, 4'h3, 4'h0, 4'h0, 4'h0, 0, 5'h0, 15'h3, 1, 32'h200C, 32'hA00C200C);
        ld(0, 3'h6, 0, 0, 4'hA, 4'h4, 4'h0, 4'h0, 0, 5'h0, 15'h0, 1, 32'h104, 32'h81040104);
        ld(0, 3'h6, 0, 0, 4'hB, 4'h4, 4'h0, 4'h8, 0, 5'h0, 15'h0, 1, 32'h100, 32'h81000100);
        chk(8'h50, 32'h00000100);
        ld(0, 3'h6, 0, 0, 4'hC, 4'h4, 4'h0, 4'h9, 1, 5'h1, 15'h0, 0, 32'h0, 32'h5A5A5A5A);
        chk(8'h50, 32'h00000100);
        ld(0, 3'h7, 0, 0, 4'hC, 4'h4, 4'h0, 4'h9, 1, 5'h1, 15'h0, 1, 32'h0, 32'h5A5A5A5A);
        ld(0, 3'h0, 0, 1, 4'h7, 4'h5, 4'h1, 4'h4, 1, 5'h0, 15'h0, 1, 32'h2FC, 32'h000002FC);
        bus(1'b1, 8'h00, 32'h00030001, v);
        chk(8'h00, 32'h00030001);
        bus(1'b1, 8'h50, 32'h0000010C, v);
        ld(0, 3'h6, 0, 0, 4'hD, 4'h4, 4'h0, 4'h9, 1, 5'h1, 15'h0, 1, 32'h100, 32'h81000100);
        chk(8'h50, 32'h00000100);
        bus(1'b1, 8'h00, 32'h00430201, v);
        bus(1'b1, 8'h90, 32'h0000020C, v);
        ld(0, 3'h6, 1, 0, 4'hF, 4'h4, 4'h0, 4'hB, 1, 5'h1, 15'h0, 1, 32'h20C, 32'h820C020C);
        chk(8'h90, 32'h00000208);
        results;
    end
endmodule
